// ---- verilog/dbm_pkg.sv ----
// constants for the data memory bank mapper
// assumes a 14-bit data address space of 64 banks of 256 bytes
package dbm_pkg;
   localparam int BANK_W = 6;
   localparam int OFS_W = 8;
   localparam int ADDR_W = BANK_W + OFS_W;
   localparam int DATA_W = 8;
   localparam logic [BANK_W-1:0] BANK_LOW = 6'h00;
   localparam logic [BANK_W-1:0] BANK_TOP = 6'h3f;
   localparam logic [BANK_W-1:0] PERIPH_FIRST_BANK = 6'h38;
   localparam logic [OFS_W-1:0] ACC_SPLIT = 8'h60;
   localparam logic [ADDR_W-1:0] PERIPH_BASE = 14'h3800;
   localparam logic [ADDR_W-1:0] MEM_TOP = 14'h3fff;
   localparam logic [ADDR_W-1:0] RESET_ADDR = 14'h0000;
   localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
   typedef enum logic [1:0] {dbm_reg_general, dbm_reg_special, dbm_reg_none} dbm_region_t;
endpackage : dbm_pkg

// ---- verilog/dbm_addr_form.sv ----
// forms the 14-bit data address from operand, access bit and bank select
// assumes operand and bank select are stable during the request cycle
`timescale 1ns/100ps
`default_nettype none
module dbm_addr_form (
   input wire logic access_sel,
   input wire logic [dbm_pkg::BANK_W-1:0] bank_sel,
   input wire logic [dbm_pkg::OFS_W-1:0] offset,
   output logic [dbm_pkg::ADDR_W-1:0] addr
);
   import dbm_pkg::*;
   always_comb begin
      if (access_sel) begin
         addr = {bank_sel, offset};
      end else if (offset < ACC_SPLIT) begin
         addr = {BANK_LOW, offset};
      end else begin
         addr = {BANK_TOP, offset};
      end
   end
endmodule : dbm_addr_form
`default_nettype wire

// ---- verilog/dbm_region_dec.sv ----
// classifies a data address as general ram, special register or unimplemented
// assumes general ram spans the low banks up to a size parameter
`timescale 1ns/100ps
`default_nettype none
module dbm_region_dec #(
   parameter int RAM_BYTES = 2048
) (
   input wire logic [dbm_pkg::ADDR_W-1:0] addr,
   input wire logic periph_impl,
   output dbm_pkg::dbm_region_t region
);
   import dbm_pkg::*;
   localparam logic [ADDR_W-1:0] RAM_LIMIT = ADDR_W'(RAM_BYTES);
   always_comb begin
      if (addr >= PERIPH_BASE && addr <= MEM_TOP) begin
         region = periph_impl ? dbm_reg_special : dbm_reg_none;
      end else if (addr < RAM_LIMIT) begin
         region = dbm_reg_general;
      end else begin
         region = dbm_reg_none;
      end
   end
endmodule : dbm_region_dec
`default_nettype wire

// ---- verilog/dbm_mapper.sv ----
// data memory bank mapper: operand address formation and read steering
// assumes cpu presents one request per cycle; peripherals answer register reads
`timescale 1ns/100ps
`default_nettype none
module dbm_mapper #(
   parameter int RAM_BYTES = 2048
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req,
   input wire logic wr,
   input wire logic access_sel,
   input wire logic [dbm_pkg::OFS_W-1:0] offset,
   input wire logic [dbm_pkg::BANK_W-1:0] bank_select_reg,
   input wire logic extended_instruction_enable,
   input wire logic [dbm_pkg::ADDR_W-1:0] ext_addr,
   input wire logic [dbm_pkg::DATA_W-1:0] wdata,
   input wire logic periph_impl,
   input wire logic [dbm_pkg::DATA_W-1:0] periph_rdata,
   output logic [dbm_pkg::ADDR_W-1:0] addr,
   output logic periph_sel,
   output logic periph_we,
   output logic [dbm_pkg::DATA_W-1:0] rdata,
   output logic rvalid
);
   import dbm_pkg::*;
   localparam int RAM_AW = $clog2(RAM_BYTES);

   logic [ADDR_W-1:0] base_addr;
   dbm_region_t region;
   logic [DATA_W-1:0] ram_mem [RAM_BYTES];
   logic [DATA_W-1:0] rdata_nxt;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;

   // bank select only reaches the address when access select is set
   dbm_addr_form u_form (
      .access_sel(access_sel),
      .bank_sel(bank_select_reg),
      .offset(offset),
      .addr(base_addr)
   );

   // extended mode hands the access map to the indexed-offset logic
   always_comb begin
      if (extended_instruction_enable && !access_sel) begin
         addr = ext_addr;
      end else begin
         addr = base_addr;
      end
   end

   dbm_region_dec #(
      .RAM_BYTES(RAM_BYTES)
   ) u_dec (
      .addr(addr),
      .periph_impl(periph_impl),
      .region(region)
   );

   assign periph_sel = req && (region == dbm_reg_special);
   assign periph_we = periph_sel && wr;

   // ram has no reset so contents survive every reset
   always_ff @(posedge clk) begin
      if (req && wr && region == dbm_reg_general) begin
         ram_mem[addr[RAM_AW-1:0]] <= wdata;
      end
   end

   always_comb begin
      rdata_nxt = ZERO_DATA;
      case (region)
         dbm_reg_general: rdata_nxt = ram_mem[addr[RAM_AW-1:0]];
         dbm_reg_special: rdata_nxt = periph_rdata;
         default: rdata_nxt = ZERO_DATA;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= ZERO_DATA;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= req && !wr;
         if (req && !wr) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign rdata = rdata_r;
   assign rvalid = rvalid_r;
endmodule : dbm_mapper
`default_nettype wire

// ---- test/dbm_checker_properties.sv ----
// mapper port checker
// bound onto dbm_mapper
`timescale 1ns/100ps
`default_nettype none
module dbm_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req,
   input wire logic wr,
   input wire logic access_sel,
   input wire logic [7:0] offset,
   input wire logic [5:0] bank_select_reg,
   input wire logic extended_instruction_enable,
   input wire logic [13:0] ext_addr,
   input wire logic periph_impl,
   input wire logic [7:0] periph_rdata,
   input wire logic [13:0] addr,
   input wire logic periph_sel,
   input wire logic periph_we,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   wire logic am = !access_sel && !extended_instruction_enable;
   wire logic rd = req && !wr;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_BANK: assert property (access_sel |-> addr == {bank_select_reg, offset})
      else $error("banked addr");
   AST_LO: assert property (am && offset < 8'h60 |-> addr == {6'h00, offset})
      else $error("low map");
   AST_HI: assert property (am && offset > 8'h5f |-> addr == {6'h3f, offset})
      else $error("high map");
   AST_EXT: assert property (!access_sel && extended_instruction_enable |-> addr == ext_addr)
      else $error("ext map");
   AST_SEL: assert property (periph_sel == (req && addr > 14'h37ff && periph_impl))
      else $error("periph select");
   AST_WE: assert property (periph_we == (req && wr && addr > 14'h37ff && periph_impl))
      else $error("periph write");
   AST_RV: assert property (rd |=> rvalid)
      else $error("no rvalid");
   AST_NRV: assert property (!rd |=> !rvalid)
      else $error("stray rvalid");
   AST_SRD: assert property (rd && periph_sel |=> rdata == $past(periph_rdata))
      else $error("periph data");
   AST_ZERO: assert property (rd && addr > 14'h37ff && !periph_impl |=> rdata == 8'h00)
      else $error("not zero");
endmodule : dbm_checker
`default_nettype wire

// ---- test/dbm_sfr_model.sv ----
// peripheral read model
// odd addresses absent
`timescale 1ns/100ps
`default_nettype none
module dbm_periph_model (
   input wire logic [13:0] addr,
   output logic periph_impl,
   output logic [7:0] periph_rdata
);
   assign periph_impl = !addr[0];
   assign periph_rdata = addr[7:0] ^ 8'ha5;
endmodule : dbm_periph_model
`default_nettype wire

// ---- test/testbench.sv ----
// mapper testbench
// needs mapper, model, checker
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 0, nrst = 0, req = 0, wr = 0, access_sel = 0, extended_instruction_enable = 0;
   logic [7:0] offset = 0, wdata = 0, rdata, periph_rdata;
   logic [5:0] bank_select_reg = 0;
   logic [13:0] ext_addr = 0, addr;
   logic periph_impl, periph_sel, periph_we, rvalid;
   int fails = 0, compares = 0;
   always #5 clk = ~clk;
   dbm_mapper u_dut (.*);
   dbm_periph_model u_periph (.*);
   task chk(input string n, input logic [13:0] e, g);
      compares++;
      if (e !== g) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task op(input logic w, a, input logic [7:0] o, input logic [5:0] b, input logic [13:0] ea,
      input logic [7:0] d);
      @(posedge clk);
      {req, wr, access_sel, offset, bank_select_reg, wdata} <= {1'b1, w, a, o, b, d};
      #1 chk("addr", ea, addr);
      chk("periph_we", {13'h0000, w && ea > 14'h37ff && !ea[0]}, {13'h0000, periph_we});
      @(posedge clk);
      {req, wr} <= 2'b00;
      #1 chk("rvalid", {13'h0000, !w}, {13'h0000, rvalid});
      if (!w) chk("rdata", {6'h00, d}, {6'h00, rdata});
   endtask : op
   task s_acc;
      op(1, 0, 8'h10, 6'h15, 14'h0010, 8'h3c);
      op(0, 1, 8'h10, 6'h00, 14'h0010, 8'h3c);
      op(1, 1, 8'h23, 6'h01, 14'h0123, 8'h77);
      @(posedge clk);
      {extended_instruction_enable, ext_addr} <= {1'b1, 14'h0123};
      op(0, 0, 8'h45, 6'h00, 14'h0123, 8'h77);
      @(posedge clk);
      extended_instruction_enable <= 0;
   endtask : s_acc
   task s_sfr;
      op(0, 0, 8'h60, 6'h11, 14'h3f60, 8'hc5);
      op(0, 0, 8'hff, 6'h11, 14'h3fff, 8'h00);
      op(1, 1, 8'h00, 6'h38, 14'h3800, 8'h11);
      op(0, 1, 8'h00, 6'h38, 14'h3800, 8'ha5);
      op(0, 1, 8'hfe, 6'h37, 14'h37fe, 8'h00);
      op(0, 1, 8'h00, 6'h08, 14'h0800, 8'h00);
   endtask : s_sfr
   task conclude;
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1;
      s_acc;
      s_sfr;
      @(posedge clk);
      nrst <= 0;
      @(posedge clk);
      nrst <= 1;
      op(0, 0, 8'h10, 6'h00, 14'h0010, 8'h3c);
      conclude;
   end
endmodule : testbench
bind dbm_mapper dbm_checker u_chk (.*);
`default_nettype wire
